// *** hw/pbcs_pkg.sv ***
`default_nettype none
package pbcs_pkg;
  // access path and soft reset counter widths
  localparam int unsigned IDX_W = 5;
  localparam int unsigned DAT_W = 16;
  localparam int unsigned CNT_W = 16;

  // basic register indexes
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STAT = 5'h01;

  // remaining decoded indexes, slot 0 is rightmost
  localparam int unsigned NUM_EXT = 13;
  localparam logic [12:0][4:0] EXT_IDX = {
    5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h1a, 5'h12, 5'h11,
    5'h10, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02};

  // per-slot bits kept over a soft reset (index 16 bit 15)
  localparam logic [12:0][15:0] EXT_KEEP = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};

  // control register fields
  localparam int unsigned CB_RESET  = 15;
  localparam int unsigned CB_LOOP   = 14;
  localparam int unsigned CB_SPEED  = 13;
  localparam int unsigned CB_ANEN   = 12;
  localparam int unsigned CB_PDOWN  = 11;
  localparam int unsigned CB_ANRST  = 9;
  localparam int unsigned CB_DUPLEX = 8;
  localparam int unsigned CB_COLT   = 7;
  localparam logic [15:0] CTRL_RST   = 16'h3000;
  localparam logic [15:0] CTRL_WMASK = 16'h7980;

  // status register fields
  localparam int unsigned SB_ANDONE = 5;
  localparam int unsigned SB_RFAULT = 4;
  localparam int unsigned SB_LINK   = 2;
  localparam int unsigned SB_JAB    = 1;
  localparam logic [15:0] STAT_FIXED = 16'h7809;
  localparam logic [15:0] STAT_FMASK = 16'hffc9;

  // raw line status vector positions
  localparam int unsigned RAW_W  = 6;
  localparam int unsigned RI_LINK = 0;
  localparam int unsigned RI_RF   = 1;
  localparam int unsigned RI_JAB  = 2;
  localparam int unsigned RI_AND  = 3;
  localparam int unsigned RI_SPD  = 4;
  localparam int unsigned RI_DUP  = 5;

  // soft reset duration
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned SRST_TIME_NS = 1000;
  localparam int unsigned SRST_CYC =
    (SRST_TIME_NS * CLK_MHZ + 999) / 1000;

  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_SRST = 2'b10
  } pbcs_state_t;
endpackage
`default_nettype wire

// *** hw/pbcs_regs.sv ***
`default_nettype none
module pbcs_regs #(
  parameter int unsigned SRST_CYC = pbcs_pkg::SRST_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // indexed management access
  input  wire logic                       mgmt_req,
  input  wire logic                       mgmt_we,
  input  wire logic [pbcs_pkg::IDX_W-1:0] mgmt_idx,
  input  wire logic [pbcs_pkg::DAT_W-1:0] mgmt_wdata,
  output logic                            mgmt_ack,
  output logic      [pbcs_pkg::DAT_W-1:0] mgmt_rdata,
  // raw line status from the analog side
  input  wire logic                       link_raw,
  input  wire logic                       rfault_raw,
  input  wire logic                       jabber_raw,
  input  wire logic                       an_done_raw,
  input  wire logic                       an_speed_raw,
  input  wire logic                       an_duplex_raw,
  // controls to the line logic
  output logic                            soft_reset,
  output logic                            loopback,
  output logic                            speed_100,
  output logic                            full_duplex,
  output logic                            an_enable,
  output logic                            an_restart,
  output logic                            power_down,
  output logic                            col_test
);
  localparam int SR_M = SRST_CYC - 1;

  typedef struct packed {
    pbcs_pkg::pbcs_state_t                      st;
    logic [pbcs_pkg::CNT_W-1:0]                 cnt;
    logic [pbcs_pkg::DAT_W-1:0]                 ctl;
    logic                                       restart;
    logic                                       spd;
    logic                                       dup;
    logic                                       ack;
    logic [pbcs_pkg::DAT_W-1:0]                 rdata;
    logic [pbcs_pkg::NUM_EXT-1:0][pbcs_pkg::DAT_W-1:0] ext;
  } pbcs_regs_st_t;

  localparam pbcs_regs_st_t RST_ST = '{
    st:      pbcs_pkg::ST_RUN,
    ctl:     pbcs_pkg::CTRL_RST,
    spd:     1'b1,
    default: '0
  };

  pbcs_regs_st_t q_r;
  pbcs_regs_st_t q_nxt;

  logic                       wr;
  logic                       rd;
  logic [4:0]                 slot;
  logic [pbcs_pkg::DAT_W-1:0] ctl_view;
  logic [pbcs_pkg::DAT_W-1:0] stat_view;
  logic [pbcs_pkg::RAW_W-1:0] raw;

  pbcs_stat_if sif ();

  // index to storage slot, NUM_EXT when not decoded
  function automatic logic [4:0] slot_of(input logic [4:0] idx);
    logic [4:0] s;
    s = 5'(pbcs_pkg::NUM_EXT);
    for (int i = 0; i < pbcs_pkg::NUM_EXT; i++) begin
      if (pbcs_pkg::EXT_IDX[i] == idx) begin
        s = 5'(i);
      end
    end
    return s;
  endfunction

  // line status sync and latching
  assign raw = {an_duplex_raw, an_speed_raw, an_done_raw,
                jabber_raw, rfault_raw, link_raw};

  pbcs_status_latch u_lat (
    .clk  (clk),
    .rstn (rstn),
    .raw  (raw),
    .stat (sif.latch)
  );

  // request qualification; writes are dropped while a soft reset runs
  assign wr   = mgmt_req & mgmt_we & (q_r.st == pbcs_pkg::ST_RUN);
  assign rd   = mgmt_req & ~mgmt_we;
  assign slot = slot_of(mgmt_idx);

  assign sif.rd_clr = rd & (mgmt_idx == pbcs_pkg::IDX_STAT);

  // control readback, reset bit high while soft reset runs
  always_comb begin
    ctl_view = q_r.ctl & pbcs_pkg::CTRL_WMASK;
    ctl_view[pbcs_pkg::CB_RESET] = (q_r.st == pbcs_pkg::ST_SRST);
  end

  // status word: fixed abilities plus live and latched bits
  always_comb begin
    stat_view = pbcs_pkg::STAT_FIXED;
    stat_view[pbcs_pkg::SB_ANDONE] = sif.an_done;
    stat_view[pbcs_pkg::SB_RFAULT] = sif.rfault;
    stat_view[pbcs_pkg::SB_LINK]   = sif.link;
    stat_view[pbcs_pkg::SB_JAB]    = sif.jabber;
  end

  // next state of the whole bank
  always_comb begin
    q_nxt         = q_r;
    q_nxt.ack     = mgmt_req;
    q_nxt.restart = 1'b0;
    q_nxt.spd = q_r.ctl[pbcs_pkg::CB_ANEN] ? sif.an_speed
                                           : q_r.ctl[pbcs_pkg::CB_SPEED];
    q_nxt.dup = q_r.ctl[pbcs_pkg::CB_ANEN] ? sif.an_duplex
                                           : q_r.ctl[pbcs_pkg::CB_DUPLEX];

    if (rd) begin
      if (mgmt_idx == pbcs_pkg::IDX_CTRL) begin
        q_nxt.rdata = ctl_view;
      end else if (mgmt_idx == pbcs_pkg::IDX_STAT) begin
        q_nxt.rdata = stat_view;
      end else begin
        q_nxt.rdata = '0;
        for (int i = 0; i < pbcs_pkg::NUM_EXT; i++) begin
          if (slot == 5'(i)) begin
            q_nxt.rdata = q_r.ext[i];
          end
        end
      end
    end

    // soft reset sequencing
    unique case (q_r.st)
      pbcs_pkg::ST_RUN: begin
        if (wr && mgmt_idx == pbcs_pkg::IDX_CTRL) begin
          if (mgmt_wdata[pbcs_pkg::CB_RESET]) begin
            q_nxt.st  = pbcs_pkg::ST_SRST;
            q_nxt.cnt = pbcs_pkg::CNT_W'(SRST_CYC - 1);
            q_nxt.ctl = pbcs_pkg::CTRL_RST;
            for (int i = 0; i < pbcs_pkg::NUM_EXT; i++) begin
              q_nxt.ext[i] = q_r.ext[i] & pbcs_pkg::EXT_KEEP[i];
            end
          end else begin
            q_nxt.ctl = mgmt_wdata & pbcs_pkg::CTRL_WMASK;
            q_nxt.restart = mgmt_wdata[pbcs_pkg::CB_ANRST];
          end
        end else if (wr) begin
          for (int i = 0; i < pbcs_pkg::NUM_EXT; i++) begin
            if (slot == 5'(i)) begin
              q_nxt.ext[i] = mgmt_wdata;
            end
          end
        end
      end
      pbcs_pkg::ST_SRST: begin
        if (q_r.cnt == '0) begin
          q_nxt.st = pbcs_pkg::ST_RUN;
        end else begin
          q_nxt.cnt = q_r.cnt - 1'b1;
        end
      end
      default: begin
        q_nxt.st = pbcs_pkg::ST_RUN;
      end
    endcase
  end

  // one register for the whole state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= RST_ST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // answer port
  assign mgmt_ack   = q_r.ack;
  assign mgmt_rdata = q_r.rdata;

  // power down, the restart pulse and other control levels
  assign soft_reset  = (q_r.st == pbcs_pkg::ST_SRST);
  assign loopback    = q_r.ctl[pbcs_pkg::CB_LOOP];
  assign speed_100   = q_r.spd;
  assign full_duplex = q_r.dup;
  assign an_enable   = q_r.ctl[pbcs_pkg::CB_ANEN];
  assign an_restart  = q_r.restart;
  assign power_down  = q_r.ctl[pbcs_pkg::CB_PDOWN];
  assign col_test    = q_r.ctl[pbcs_pkg::CB_COLT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wr_ctl;
    wr && mgmt_idx == pbcs_pkg::IDX_CTRL;
  endsequence

  property p_ack;
    mgmt_req |=> mgmt_ack ##1 (!mgmt_ack || $past(mgmt_req));
  endproperty
  a_ack: assert property (p_ack)
    else $error("management request not answered next cycle");

  property p_unmapped;
    rd && mgmt_idx > pbcs_pkg::IDX_STAT
       && slot_of(mgmt_idx) == 5'(pbcs_pkg::NUM_EXT)
    |=> mgmt_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("undecoded index did not read zero");

  property p_keep;
    s_wr_ctl and mgmt_wdata[pbcs_pkg::CB_RESET]
    |=> q_r.ext[5] == ($past(q_r.ext[5]) & pbcs_pkg::EXT_KEEP[5])
        && q_r.ext[0] == '0;
  endproperty
  a_keep: assert property (p_keep)
    else $error("soft reset did not keep or clear fields");

  property p_srst_len;
    s_wr_ctl and mgmt_wdata[pbcs_pkg::CB_RESET]
    |=> soft_reset ##SR_M soft_reset ##1 !soft_reset
        && an_enable && !power_down && !col_test && !loopback;
  endproperty
  a_srst_len: assert property (p_srst_len)
    else $error("soft reset length or end state wrong");

  property p_manual;
    !q_r.ctl[pbcs_pkg::CB_ANEN] |=>
      speed_100 == $past(q_r.ctl[pbcs_pkg::CB_SPEED])
      && full_duplex == $past(q_r.ctl[pbcs_pkg::CB_DUPLEX]);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual speed or duplex not applied");

  property p_an_ovr;
    q_r.ctl[pbcs_pkg::CB_ANEN] |=>
      speed_100 == $past(sif.an_speed)
      && full_duplex == $past(sif.an_duplex);
  endproperty
  a_an_ovr: assert property (p_an_ovr)
    else $error("negotiated result not used while enabled");

  property p_pdown;
    s_wr_ctl and !mgmt_wdata[pbcs_pkg::CB_RESET]
    |=> power_down == $past(mgmt_wdata[pbcs_pkg::CB_PDOWN])
        && col_test == $past(mgmt_wdata[pbcs_pkg::CB_COLT]);
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power down or collision test not written");

  property p_anen_wr;
    s_wr_ctl and !mgmt_wdata[pbcs_pkg::CB_RESET]
    |=> an_enable == $past(mgmt_wdata[pbcs_pkg::CB_ANEN])
        && loopback == $past(mgmt_wdata[pbcs_pkg::CB_LOOP]);
  endproperty
  a_anen_wr: assert property (p_anen_wr)
    else $error("negotiation enable or loopback not written");

  property p_srst_hold;
    soft_reset && mgmt_req && mgmt_we
    |=> $stable(q_r.ctl) && $stable(q_r.ext);
  endproperty
  a_srst_hold: assert property (p_srst_hold)
    else $error("write landed while soft reset ran");

  property p_rsvd_drop;
    s_wr_ctl and !mgmt_wdata[pbcs_pkg::CB_RESET]
    |=> (q_r.ctl & ~pbcs_pkg::CTRL_WMASK) == '0;
  endproperty
  a_rsvd_drop: assert property (p_rsvd_drop)
    else $error("reserved control bits stored");

  property p_restart;
    s_wr_ctl and !mgmt_wdata[pbcs_pkg::CB_RESET]
    |=> an_restart == $past(mgmt_wdata[pbcs_pkg::CB_ANRST])
        ##1 !an_restart || $past(wr);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pulse wrong");

  property p_ctl_bit9;
    rd && mgmt_idx == pbcs_pkg::IDX_CTRL |=> !mgmt_rdata[pbcs_pkg::CB_ANRST]
      && mgmt_rdata[pbcs_pkg::CB_COLT-1:0] == '0;
  endproperty
  a_ctl_bit9: assert property (p_ctl_bit9)
    else $error("self-clearing or reserved control bits read one");

  property p_fixed;
    rd && mgmt_idx == pbcs_pkg::IDX_STAT |=>
      (mgmt_rdata & pbcs_pkg::STAT_FMASK) == pbcs_pkg::STAT_FIXED;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed status bits wrong");

  property p_andone;
    rd && mgmt_idx == pbcs_pkg::IDX_STAT |=>
      mgmt_rdata[pbcs_pkg::SB_ANDONE] == $past(sif.an_done)
      && mgmt_rdata[pbcs_pkg::SB_LINK] == $past(sif.link);
  endproperty
  a_andone: assert property (p_andone)
    else $error("status read does not show live state");

  c_srst_done: cover property ($fell(soft_reset));
  c_restart:   cover property (an_restart);
  c_link_rd:   cover property (sif.rd_clr && sif.link);
  c_fault_rd:  cover property (sif.rd_clr && sif.rfault);
endmodule
`default_nettype wire

// *** hw/pbcs_stat_if.sv ***
`default_nettype none
interface pbcs_stat_if;
  logic rd_clr;
  logic link;
  logic rfault;
  logic jabber;
  logic an_done;
  logic an_speed;
  logic an_duplex;

  modport latch (
    input  rd_clr,
    output link, rfault, jabber, an_done, an_speed, an_duplex
  );
  modport user (
    output rd_clr,
    input  link, rfault, jabber, an_done, an_speed, an_duplex
  );
endinterface
`default_nettype wire

// *** hw/pbcs_status_latch.sv ***
`default_nettype none
module pbcs_status_latch (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // raw line status
  input  wire logic [pbcs_pkg::RAW_W-1:0]   raw,
  // latched view
  pbcs_stat_if.latch                        stat
);
  typedef struct packed {
    logic [pbcs_pkg::RAW_W-1:0] s1;
    logic [pbcs_pkg::RAW_W-1:0] s2;
    logic                       link;
    logic                       rfault;
    logic                       jabber;
  } pbcs_lat_st_t;

  pbcs_lat_st_t q_r;
  pbcs_lat_st_t q_nxt;

  // sync stages and latch cells, a new event wins over the read release
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = raw;
    q_nxt.s2 = q_r.s1;
    q_nxt.rfault = stat.rd_clr ? q_r.s2[pbcs_pkg::RI_RF]
                               : q_r.rfault | q_r.s2[pbcs_pkg::RI_RF];
    q_nxt.jabber = stat.rd_clr ? q_r.s2[pbcs_pkg::RI_JAB]
                               : q_r.jabber | q_r.s2[pbcs_pkg::RI_JAB];
    q_nxt.link   = stat.rd_clr ? q_r.s2[pbcs_pkg::RI_LINK]
                               : q_r.link & q_r.s2[pbcs_pkg::RI_LINK];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // latched and live values out
  assign stat.link      = q_r.link;
  assign stat.rfault    = q_r.rfault;
  assign stat.jabber    = q_r.jabber;
  assign stat.an_done   = q_r.s2[pbcs_pkg::RI_AND];
  assign stat.an_speed  = q_r.s2[pbcs_pkg::RI_SPD];
  assign stat.an_duplex = q_r.s2[pbcs_pkg::RI_DUP];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_fault_hold;
    stat.rfault && !stat.rd_clr |=> stat.rfault;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("remote fault latch dropped without read");

  property p_jab_set;
    q_r.s2[pbcs_pkg::RI_JAB] |=> stat.jabber;
  endproperty
  a_jab_set: assert property (p_jab_set)
    else $error("jabber event not latched");

  property p_link_low;
    !q_r.s2[pbcs_pkg::RI_LINK] ##1 !stat.rd_clr [*2] |=> !stat.link;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("link loss not held low");
endmodule
`default_nettype wire

// *** sim/pbcs_mac_model.sv ***
`default_nettype none
module pbcs_mac_model (
  // clock
  input  wire logic                       clk,
  // request lines towards the register bank
  output logic                            mgmt_req,
  output logic                            mgmt_we,
  output logic      [pbcs_pkg::IDX_W-1:0] mgmt_idx,
  output logic      [pbcs_pkg::DAT_W-1:0] mgmt_wdata,
  // answer lines from the register bank
  input  wire logic                       mgmt_ack,
  input  wire logic [pbcs_pkg::DAT_W-1:0] mgmt_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle request lines from time zero
  initial begin
    mgmt_req = 1'b0;
    mgmt_we = 1'b0;
    mgmt_idx = '0;
    mgmt_wdata = '0;
  end

  // one indexed access, optionally after some idle cycles
  // indexed access only
  task automatic access(input logic w, input logic [4:0] i,
                        input logic [15:0] d, input int gap,
                        output logic [15:0] q, output logic ok);
    int n;
    repeat (gap) @(negedge clk);
    @(negedge clk);
    mgmt_req = 1'b1;
    mgmt_we = w;
    mgmt_idx = i;
    mgmt_wdata = d;
    @(negedge clk);
    // released lines show the inverse, never the last value
    mgmt_req = 1'b0;
    mgmt_we = ~w;
    mgmt_idx = ~i;
    mgmt_wdata = ~d;
    n = 0;
    while (mgmt_ack !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    ok = mgmt_ack;
    q = mgmt_rdata;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_pbcs_regs.sv ***
`default_nettype none
module tb_pbcs_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rstn, mgmt_req, mgmt_we, mgmt_ack;
  logic [4:0]  mgmt_idx;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic        link_raw, rfault_raw, jabber_raw;
  logic        an_done_raw, an_speed_raw, an_duplex_raw;
  logic        soft_reset, loopback, speed_100, full_duplex;
  logic        an_enable, an_restart, power_down, col_test;
  int          miscompares, comparisons, restarts, srst_cnt;

  // short soft reset keeps the run brief
  pbcs_regs #(.SRST_CYC(8)) u_pbcs_regs (
    .clk(clk), .rstn(rstn), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we),
    .mgmt_idx(mgmt_idx), .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata), .link_raw(link_raw),
    .rfault_raw(rfault_raw), .jabber_raw(jabber_raw),
    .an_done_raw(an_done_raw), .an_speed_raw(an_speed_raw),
    .an_duplex_raw(an_duplex_raw), .soft_reset(soft_reset),
    .loopback(loopback), .speed_100(speed_100),
    .full_duplex(full_duplex), .an_enable(an_enable),
    .an_restart(an_restart), .power_down(power_down),
    .col_test(col_test));

  pbcs_mac_model u_pbcs_mac_model (
    .clk(clk), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we),
    .mgmt_idx(mgmt_idx), .mgmt_wdata(mgmt_wdata),
    .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // count restart pulses and soft reset cycles
  always @(posedge clk) begin
    if (an_restart === 1'b1) restarts++;
    if (soft_reset === 1'b1) srst_cnt++;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp,
                         input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    u_pbcs_mac_model.access(1'b1, i, d, int'(i[1:0]), q, ok);
    chk_bit(ok, 1'b1, "write ack");
  endtask

  task automatic rd(input logic [4:0] i, input logic [15:0] e,
                    input string what);
    logic [15:0] q;
    logic        ok;
    u_pbcs_mac_model.access(1'b0, i, 16'h0000, 0, q, ok);
    chk_bit(ok, 1'b1, "read ack");
    chk_word(q, e, what);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
  endtask

  task automatic t_reset_vals();
    chk_bit(an_enable, 1'b1, "an enable");
    chk_bit(col_test, 1'b0, "col test");
    rd(5'h00, 16'h3000, "ctrl reset");
    rd(5'h01, 16'h7809, "stat reset");
  endtask

  task automatic t_decode();
    for (int k = 2; k < 32; k++) wr(5'(k), 16'h5a00 | 16'(k));
    for (int k = 2; k < 32; k++)
      rd(5'(k), (k inside {[2:6], [16:18], 26, 27, [29:31]}) ?
         (16'h5a00 | 16'(k)) : 16'h0000, "decode");
  endtask

  task automatic t_ctrl();
    // negotiation cleared before power down
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h6dff);
    @(negedge clk);
    chk_bit(loopback, 1'b1, "loopback");
    chk_bit(an_enable, 1'b0, "an disabled");
    chk_bit(speed_100, 1'b1, "manual speed");
    chk_bit(full_duplex, 1'b1, "manual duplex");
    chk_bit(power_down, 1'b1, "power down");
    chk_bit(col_test, 1'b1, "col test on");
    rd(5'h00, 16'h6980, "ctrl reserved");
    wr(5'h00, 16'h0000);
    @(negedge clk);
    chk_bit(power_down, 1'b0, "power up");
    chk_bit(speed_100, 1'b0, "10 Mbps");
    chk_bit(col_test, 1'b0, "col test off");
    chk_bit(full_duplex, 1'b0, "half duplex");
  endtask

  task automatic t_autoneg();
    wr(5'h00, 16'h1000);
    an_speed_raw = 1'b1;
    an_duplex_raw = 1'b1;
    repeat (5) @(negedge clk);
    chk_bit(speed_100, 1'b1, "neg speed");
    chk_bit(full_duplex, 1'b1, "neg duplex");
    an_speed_raw = 1'b0;
    an_duplex_raw = 1'b0;
    wr(5'h00, 16'h3100);
    repeat (5) @(negedge clk);
    chk_bit(speed_100, 1'b0, "speed ignored");
    chk_bit(full_duplex, 1'b0, "duplex ignored");
  endtask

  task automatic t_restart();
    restarts = 0;
    wr(5'h00, 16'h1200);
    wr(5'h00, 16'h1000);
    repeat (2) @(negedge clk);
    chk_word(16'(restarts), 16'h0001, "restart pulses");
    rd(5'h00, 16'h1000, "restart clears");
  endtask

  task automatic t_status();
    link_raw = 1'b1;
    rfault_raw = 1'b1;
    jabber_raw = 1'b1;
    an_done_raw = 1'b1;
    repeat (5) @(negedge clk);
    rfault_raw = 1'b0;
    jabber_raw = 1'b0;
    repeat (5) @(negedge clk);
    rd(5'h01, 16'h783b, "latched events");
    rd(5'h01, 16'h782d, "released");
    link_raw = 1'b0;
    repeat (5) @(negedge clk);
    link_raw = 1'b1;
    repeat (5) @(negedge clk);
    rd(5'h01, 16'h7829, "link latched low");
    rd(5'h01, 16'h782d, "link back");
    wr(5'h01, 16'hffff);
    rd(5'h01, 16'h782d, "status read only");
    an_done_raw = 1'b0;
    repeat (5) @(negedge clk);
    rd(5'h01, 16'h780d, "neg not done");
  endtask

  task automatic t_soft_reset();
    int n;
    wr(5'h10, 16'hffff);
    wr(5'h00, 16'h0080);
    srst_cnt = 0;
    // reset request carries no other bits
    wr(5'h00, 16'h8000);
    chk_bit(soft_reset, 1'b1, "soft reset on");
    rd(5'h00, 16'hb000, "ctrl in reset");
    wr(5'h00, 16'h0080);
    n = 0;
    while (soft_reset === 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk_word(16'(srst_cnt), 16'h0008, "reset length");
    rd(5'h00, 16'h3000, "ctrl after reset");
    chk_bit(col_test, 1'b0, "normal mode");
    rd(5'h10, 16'h8000, "kept bit");
  endtask

  task automatic t_hard_reset();
    do_reset();
    rd(5'h10, 16'h0000, "kept bit cleared");
    rd(5'h00, 16'h3000, "ctrl hard reset");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of about one microsecond
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    {link_raw, rfault_raw, jabber_raw} = 3'b000;
    {an_done_raw, an_speed_raw, an_duplex_raw} = 3'b000;
    miscompares = 0;
    comparisons = 0;
    restarts = 0;
    srst_cnt = 0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset_vals();
    t_decode();
    t_ctrl();
    t_autoneg();
    t_restart();
    t_status();
    t_soft_reset();
    t_hard_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
